// ### src/cps_params.svh
/*
 Constants for the processor programming-model core: widths, reset values,
 opcodes, the two-byte opcode range and the interrupt vector. Included by the package; the core file uses its macros without an include.
*/
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_IP_W 14
`define CPS_IP_LO_W 8
`define CPS_IP_RESET 14'h0000
`define CPS_PTR_RESET 8'h00
`define CPS_ZERO8 8'h00
`define CPS_ONE8 8'h01
`define CPS_OP_HALT 8'h00
`define CPS_OP_MOV_A_D 8'h19
`define CPS_OP_MOV_A_M 8'h1A
`define CPS_OP_MOV_A_X 8'h1B
`define CPS_OP_MOV_X_D 8'h1C
`define CPS_OP_MOV_X_M 8'h1D
`define CPS_OP_PAGE 8'h1F
`define CPS_OP_POP_A 8'h2B
`define CPS_OP_POP_X 8'h2C
`define CPS_OP_PUSH_A 8'h2D
`define CPS_OP_PUSH_X 8'h2E
`define CPS_OP_SWAP_AX 8'h2F
`define CPS_OP_SWAP_AD 8'h30
`define CPS_OP_ST_M 8'h31
`define CPS_OP_ST_X 8'h32
`define CPS_OP_SUBRET 8'h3F
`define CPS_OP_MOV_AX 8'h40
`define CPS_OP_MOV_XA 8'h41
`define CPS_OP_LDCSP 8'h60
`define CPS_OP_DI 8'h70
`define CPS_OP_EI 8'h72
`define CPS_OP_IRET 8'h73
`define CPS_CALL_HI4_A 4'h5
`define CPS_CALL_HI4_B 4'h9
`define CPS_JMP_HI4 4'h8
`define CPS_TWO_BYTE_MIN 8'h01
`define CPS_TWO_BYTE_MAX 8'h1D
`define CPS_INT_VEC_HI 6'h00
`endif

// ### src/cps_pkg.sv
/*
 Types shared by the core and its bus helper.
 Assumes cps_params.svh is on the include path.
*/
`include "cps_params.svh"
package cps_pkg;
	// One RAM request toward data memory
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cps_ram_req_type;
	// One program memory fetch request
	typedef struct packed {
		logic rd;
		logic [`CPS_IP_W-1:0] addr;
	} cps_fetch_req_type;
	typedef enum logic [3:0] {
		CPS_FETCH, CPS_FETCH_WAIT, CPS_OPER, CPS_OPER_WAIT, CPS_EXEC, CPS_MEM_WAIT,
		CPS_PUSH1, CPS_PUSH2, CPS_POP1, CPS_POP2, CPS_POP_DONE, CPS_HALTED
	} cps_state_type;
endpackage : cps_pkg

// ### src/cps_addr_gen.sv
/*
 Operand address generator: direct and indexed address forms.
 Assumes its inputs come from registers of the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module cps_addr_gen
(
	input wire logic [7:0] operand, // Constant byte of the instruction
	input wire logic [7:0] index, // Auxiliary operand register
	input wire logic indexed, // High selects indexed form
	output logic [7:0] addr // Resulting RAM address
);
	// Sum wraps within the 8-bit data space
	always_comb
	begin
		if (indexed)
			addr = 8'(operand + index);
		else
			addr = operand;
	end
endmodule // cps_addr_gen
`default_nettype wire

// ### src/cps_core.sv
/*
 Programming-model core: instruction pointer, call stack, data stack,
 accumulator, auxiliary register and operand addressing.
 Assumes program memory and data RAM that answer in the same cycle as the registered request.
*/
`timescale 1ns/10ps
`default_nettype none
module cps_core
(
	input wire logic clk, // 40 MHz core clock
	input wire logic resetn, // Asynchronous reset, active low
	output cps_pkg::cps_fetch_req_type fetch_req, // Program memory request
	input wire logic [7:0] fetch_data, // Program byte, same cycle as the request
	output cps_pkg::cps_ram_req_type ram_req, // Data RAM request
	input wire logic [7:0] ram_rdata, // RAM read data, same cycle as the request
	input wire logic irq_req, // Interrupt request level, same clock
	input wire logic carry_in, // Carry flag from the arithmetic unit
	input wire logic zero_in, // Zero flag from the arithmetic unit
	output logic irq_ack, // Pulse when an interrupt is taken
	output logic irq_enabled, // Global interrupt enable
	output logic carry_out, // Carry flag held by the core
	output logic zero_out, // Zero flag held by the core
	output logic [7:0] acc_out, // Accumulator
	output logic [7:0] aux_out, // Auxiliary operand register
	output logic halted // High after the halt instruction
);
	import cps_pkg::*;

	cps_state_type state_reg;
	logic [`CPS_IP_W-1:0] ip_reg;
	logic [7:0] opcode_reg;
	logic [7:0] operand_reg;
	logic [7:0] csp_reg;
	logic [7:0] dsp_reg;
	logic [7:0] acc_reg;
	logic [7:0] aux_reg;
	logic carry_reg;
	logic zero_reg;
	logic ie_reg;
	logic restore_flags_reg;
	logic [7:0] pop_low_reg;
	logic [`CPS_IP_W-1:0] save_ip_reg;
	logic pop_to_aux_reg;
	logic [7:0] op_addr;
	logic indexed;
	logic two_byte;
	logic [7:0] ip_lo_inc;
	logic [7:0] byte_one;
	logic [7:0] byte_two;

	// Immediate and memory-operand opcodes carry a second byte
	assign two_byte = (fetch_data >= `CPS_TWO_BYTE_MIN && fetch_data <= `CPS_TWO_BYTE_MAX)
		|| fetch_data == `CPS_OP_ST_M || fetch_data == `CPS_OP_ST_X
		|| fetch_data[7] || fetch_data[7:4] == `CPS_CALL_HI4_A;
	// Low byte increment wraps in the page
	assign ip_lo_inc = 8'(ip_reg[`CPS_IP_LO_W-1:0] + `CPS_ONE8);
	assign indexed = opcode_reg == `CPS_OP_MOV_A_X || opcode_reg == `CPS_OP_ST_X;
	// Saved byte layout: {carry, zero, ip[13:8]} then ip[7:0]
	assign byte_one = {carry_reg, zero_reg, save_ip_reg[`CPS_IP_W-1:`CPS_IP_LO_W]};
	assign byte_two = save_ip_reg[`CPS_IP_LO_W-1:0];

	cps_addr_gen u_addr_gen
	(
		.operand(operand_reg),
		.index(aux_reg),
		.indexed(indexed),
		.addr(op_addr)
	);

	// Sequencer and instruction pointer; firmware changes it only by jump, call, return and page
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= CPS_FETCH;
			ip_reg <= `CPS_IP_RESET;
			opcode_reg <= `CPS_ZERO8;
			operand_reg <= `CPS_ZERO8;
			save_ip_reg <= `CPS_IP_RESET;
			restore_flags_reg <= 1'b0;
			pop_to_aux_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				CPS_FETCH:
				begin
					if (irq_req && ie_reg)
					begin
						save_ip_reg <= ip_reg;
						ip_reg <= {`CPS_INT_VEC_HI, `CPS_ZERO8};
						state_reg <= CPS_PUSH1;
					end
					else
						state_reg <= CPS_FETCH_WAIT;
				end
				CPS_FETCH_WAIT:
				begin
					opcode_reg <= fetch_data;
					ip_reg[`CPS_IP_LO_W-1:0] <= ip_lo_inc;
					state_reg <= two_byte ? CPS_OPER : CPS_EXEC;
				end
				CPS_OPER:
					state_reg <= CPS_OPER_WAIT;
				CPS_OPER_WAIT:
				begin
					operand_reg <= fetch_data;
					ip_reg[`CPS_IP_LO_W-1:0] <= ip_lo_inc;
					state_reg <= CPS_EXEC;
				end
				CPS_EXEC:
				begin
					state_reg <= CPS_FETCH;
					if (opcode_reg == `CPS_OP_PAGE)
						ip_reg[`CPS_IP_W-1:`CPS_IP_LO_W] <= 6'(ip_reg[`CPS_IP_W-1:`CPS_IP_LO_W] + 6'h01);
					else if (opcode_reg[7:4] == `CPS_JMP_HI4)
						ip_reg <= {2'b00, opcode_reg[3:0], operand_reg};
					else if (opcode_reg[7:4] == `CPS_CALL_HI4_A || opcode_reg[7:4] == `CPS_CALL_HI4_B)
					begin
						save_ip_reg <= ip_reg;
						ip_reg <= {2'b00, opcode_reg[3:0], operand_reg};
						state_reg <= CPS_PUSH1;
					end
					else if (opcode_reg == `CPS_OP_IRET || opcode_reg == `CPS_OP_SUBRET)
					begin
						restore_flags_reg <= opcode_reg == `CPS_OP_IRET;
						state_reg <= CPS_POP1;
					end
					else if (opcode_reg == `CPS_OP_POP_A || opcode_reg == `CPS_OP_POP_X)
					begin
						pop_to_aux_reg <= opcode_reg == `CPS_OP_POP_X;
						state_reg <= CPS_MEM_WAIT;
					end
					else if (opcode_reg == `CPS_OP_MOV_A_M || opcode_reg == `CPS_OP_MOV_A_X
						|| opcode_reg == `CPS_OP_MOV_X_M)
					begin
						pop_to_aux_reg <= opcode_reg == `CPS_OP_MOV_X_M;
						state_reg <= CPS_MEM_WAIT;
					end
					else if (opcode_reg == `CPS_OP_HALT)
						state_reg <= CPS_HALTED;
				end
				CPS_MEM_WAIT:
					state_reg <= CPS_FETCH;
				CPS_PUSH1:
					state_reg <= CPS_PUSH2;
				CPS_PUSH2:
					state_reg <= CPS_FETCH;
				CPS_POP1:
					state_reg <= CPS_POP2;
				CPS_POP2:
					state_reg <= CPS_POP_DONE;
				CPS_POP_DONE:
				begin
					ip_reg <= {ram_rdata[`CPS_IP_W-`CPS_IP_LO_W-1:0], pop_low_reg};
					state_reg <= CPS_FETCH;
				end
				CPS_HALTED:
					state_reg <= CPS_HALTED;
				default:
					state_reg <= CPS_FETCH;
			endcase
		end
	end

	// Call stack pointer: up by two on entry, down by two on return
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			csp_reg <= `CPS_PTR_RESET;
		else if (state_reg == CPS_PUSH1 || state_reg == CPS_PUSH2)
			csp_reg <= 8'(csp_reg + `CPS_ONE8);
		else if (state_reg == CPS_POP1 || state_reg == CPS_POP2)
			csp_reg <= 8'(csp_reg - `CPS_ONE8);
		else if (state_reg == CPS_EXEC && opcode_reg == `CPS_OP_LDCSP)
			csp_reg <= acc_reg;
	end

	// Byte two (low address bits) comes off first; byte one with the flags follows
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pop_low_reg <= `CPS_ZERO8;
		else if (state_reg == CPS_POP2)
			pop_low_reg <= ram_rdata;
	end

	// Data stack pointer: pre-decrement on push, post-increment on pop
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			dsp_reg <= `CPS_PTR_RESET;
		else if (state_reg == CPS_EXEC)
		begin
			if (opcode_reg == `CPS_OP_PUSH_A || opcode_reg == `CPS_OP_PUSH_X)
				dsp_reg <= 8'(dsp_reg - `CPS_ONE8);
			else if (opcode_reg == `CPS_OP_POP_A || opcode_reg == `CPS_OP_POP_X)
				dsp_reg <= 8'(dsp_reg + `CPS_ONE8);
			else if (opcode_reg == `CPS_OP_SWAP_AD)
				dsp_reg <= acc_reg;
		end
	end

	// Accumulator and auxiliary register moves
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_reg <= `CPS_ZERO8;
			aux_reg <= `CPS_ZERO8;
		end
		else if (state_reg == CPS_MEM_WAIT)
		begin
			if (pop_to_aux_reg)
				aux_reg <= ram_rdata;
			else
				acc_reg <= ram_rdata;
		end
		else if (state_reg == CPS_EXEC)
		begin
			case (opcode_reg)
				`CPS_OP_MOV_A_D: acc_reg <= operand_reg;
				`CPS_OP_MOV_X_D: aux_reg <= operand_reg;
				`CPS_OP_SWAP_AX:
				begin
					acc_reg <= aux_reg;
					aux_reg <= acc_reg;
				end
				`CPS_OP_SWAP_AD: acc_reg <= dsp_reg;
				`CPS_OP_MOV_AX: acc_reg <= aux_reg;
				`CPS_OP_MOV_XA: aux_reg <= acc_reg;
				default: acc_reg <= acc_reg;
			endcase
		end
	end

	// Flags follow the arithmetic unit except while interrupt return restores them
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			carry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end
		else if (state_reg == CPS_POP_DONE)
		begin
			if (restore_flags_reg)
			begin
				carry_reg <= ram_rdata[`CPS_IP_LO_W-1];
				zero_reg <= ram_rdata[`CPS_IP_LO_W-2];
			end
		end
		else if (state_reg == CPS_EXEC)
		begin
			carry_reg <= carry_in;
			zero_reg <= zero_in;
		end
	end

	// Interrupt enable: off on acknowledge, on after interrupt return completes
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ie_reg <= 1'b0;
		else if (state_reg == CPS_FETCH && irq_req && ie_reg)
			ie_reg <= 1'b0;
		else if (state_reg == CPS_POP_DONE && restore_flags_reg)
			ie_reg <= 1'b1;
		else if (state_reg == CPS_EXEC && opcode_reg == `CPS_OP_EI)
			ie_reg <= 1'b1;
		else if (state_reg == CPS_EXEC && opcode_reg == `CPS_OP_DI)
			ie_reg <= 1'b0;
	end

	// Registered memory requests
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fetch_req <= '0;
			ram_req <= '0;
		end
		else
		begin
			fetch_req.rd <= (state_reg == CPS_FETCH && !(irq_req && ie_reg)) || state_reg == CPS_OPER;
			fetch_req.addr <= ip_reg;
			ram_req <= '0;
			case (state_reg)
				CPS_PUSH1: ram_req <= '{rd: 1'b0, wr: 1'b1, addr: csp_reg, wdata: byte_one};
				CPS_PUSH2: ram_req <= '{rd: 1'b0, wr: 1'b1, addr: csp_reg, wdata: byte_two};
				CPS_POP1: ram_req <= '{rd: 1'b1, wr: 1'b0, addr: 8'(csp_reg - `CPS_ONE8), wdata: `CPS_ZERO8};
				CPS_POP2: ram_req <= '{rd: 1'b1, wr: 1'b0, addr: 8'(csp_reg - `CPS_ONE8), wdata: `CPS_ZERO8};
				CPS_EXEC:
				begin
					if (opcode_reg == `CPS_OP_PUSH_A || opcode_reg == `CPS_OP_PUSH_X)
						ram_req <= '{rd: 1'b0, wr: 1'b1, addr: 8'(dsp_reg - `CPS_ONE8),
							wdata: opcode_reg == `CPS_OP_PUSH_X ? aux_reg : acc_reg};
					else if (opcode_reg == `CPS_OP_POP_A || opcode_reg == `CPS_OP_POP_X)
						ram_req <= '{rd: 1'b1, wr: 1'b0, addr: dsp_reg, wdata: `CPS_ZERO8};
					else if (opcode_reg == `CPS_OP_MOV_A_M || opcode_reg == `CPS_OP_MOV_A_X
						|| opcode_reg == `CPS_OP_MOV_X_M)
						ram_req <= '{rd: 1'b1, wr: 1'b0, addr: op_addr, wdata: `CPS_ZERO8};
					else if (opcode_reg == `CPS_OP_ST_M || opcode_reg == `CPS_OP_ST_X)
						ram_req <= '{rd: 1'b0, wr: 1'b1, addr: op_addr, wdata: acc_reg};
				end
				default: ram_req <= '0;
			endcase
		end
	end

	// Status outputs from flip-flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_ack <= 1'b0;
			irq_enabled <= 1'b0;
			carry_out <= 1'b0;
			zero_out <= 1'b0;
			acc_out <= `CPS_ZERO8;
			aux_out <= `CPS_ZERO8;
			halted <= 1'b0;
		end
		else
		begin
			irq_ack <= state_reg == CPS_FETCH && irq_req && ie_reg;
			irq_enabled <= ie_reg;
			carry_out <= carry_reg;
			zero_out <= zero_reg;
			acc_out <= acc_reg;
			aux_out <= aux_reg;
			halted <= state_reg == CPS_HALTED;
		end
	end
endmodule // cps_core
`default_nettype wire

// ### bench/cps_core_asserts.sv
/*
 Checker for the core ports: reset state, fetch pulses, RAM strobes, interrupt entry.
 Assumes it is bound to cps_core and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module cps_core_asserts
(
	input wire logic clk, // Core clock
	input wire logic resetn, // Reset, active low
	input wire cps_pkg::cps_fetch_req_type fetch_req, // Fetch request
	input wire cps_pkg::cps_ram_req_type ram_req, // RAM request
	input wire logic irq_req, // Interrupt request
	input wire logic irq_ack, // Interrupt taken
	input wire logic irq_enabled, // Interrupt enable
	input wire logic [7:0] acc_out // Accumulator
);
	import cps_pkg::*;
	logic first_reg; // High until the first fetch after reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Remember whether the first fetch since reset is still due
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			first_reg <= 1'h1;
		else if (fetch_req.rd)
			first_reg <= 1'h0;
	end
	// Interrupt entry stores two stack bytes close together
	sequence s_entry_push;
		ram_req.wr ##[1:3] ram_req.wr;
	endsequence
	a_reset_quiet: assert property (disable iff (1'h0) !resetn |=> fetch_req == '0 && ram_req == '0)
		else $error("requests active during reset");
	a_first_fetch: assert property (fetch_req.rd && first_reg |-> fetch_req.addr == 14'h0000)
		else $error("first fetch not at address zero");
	a_fetch_start: assert property ($rose(resetn) |-> ##[0:3] fetch_req.rd)
		else $error("no fetch soon after reset");
	a_fetch_pulse: assert property (fetch_req.rd |=> !fetch_req.rd)
		else $error("fetch strobe longer than one cycle");
	a_ram_exclusive: assert property (!(ram_req.rd && ram_req.wr))
		else $error("RAM read and write together");
	a_ack_disables: assert property (irq_ack |-> ##[0:1] !irq_enabled)
		else $error("interrupts still enabled after entry");
	a_entry_push: assert property (irq_ack |-> ##[0:8] s_entry_push)
		else $error("interrupt entry did not store two bytes");
	a_ack_cause: assert property (irq_ack |-> $past(irq_req) || $past(irq_req, 2))
		else $error("interrupt taken without request");
	a_reset_acc: assert property (disable iff (1'h0) !resetn |=> acc_out == 8'h00)
		else $error("accumulator not cleared by reset");
endmodule // cps_core_asserts
`default_nettype wire

// ### bench/cps_mem_model.sv
/*
 Program memory and data RAM beside the core; a read answers while its registered request stands.
 Assumes the bench loads prog and ram directly before each reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cps_mem_model
(
	input wire logic clk, // Core clock
	input wire cps_pkg::cps_fetch_req_type fetch_req, // Fetch request
	output logic [7:0] fetch_data, // Program byte
	input wire cps_pkg::cps_ram_req_type ram_req, // RAM request
	output logic [7:0] ram_rdata // RAM read data
);
	import cps_pkg::*;
	logic [7:0] prog [0:16383]; // Program store
	logic [7:0] ram [0:255]; // Stacks and variables
	logic [7:0] fetch_last; // Last byte shown on the program bus
	logic [7:0] ram_last; // Last byte shown on the RAM bus
	// Known start so the idle inversion is defined
	initial
	begin
		fetch_last = 8'h00;
		ram_last = 8'h00;
	end
	// Answer stands with the request; an idle bus shows the inverse of its last byte
	assign fetch_data = fetch_req.rd ? prog[fetch_req.addr] : ~fetch_last;
	assign ram_rdata = ram_req.rd ? ram[ram_req.addr] : ~ram_last;
	always @(posedge clk)
	begin
		fetch_last <= fetch_data;
		ram_last <= ram_rdata;
	end
	// Saved stack bytes land in plain RAM and stay readable
	always @(posedge clk)
	begin
		if (ram_req.wr)
			ram[ram_req.addr] <= ram_req.wdata;
	end
endmodule // cps_mem_model
`default_nettype wire

// ### bench/cps_core_bench.sv
/*
 Self-checking bench for the core: addressing, data stack, call stack, paging, interrupts.
 Assumes cps_core, cps_mem_model and cps_core_asserts are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module cps_core_bench;
	import cps_pkg::*;
	logic clk, resetn, irq_req, carry_in, zero_in, irq_ack, irq_enabled, carry_out, zero_out, halted;
	cps_fetch_req_type fetch_req;
	cps_ram_req_type ram_req;
	logic [7:0] fetch_data, ram_rdata, acc_out, aux_out;
	int errors, tests_run, i;
	// Core under test and its memories
	cps_core uut (.clk(clk), .resetn(resetn), .fetch_req(fetch_req), .fetch_data(fetch_data),
		.ram_req(ram_req), .ram_rdata(ram_rdata), .irq_req(irq_req), .carry_in(carry_in),
		.zero_in(zero_in), .irq_ack(irq_ack), .irq_enabled(irq_enabled), .carry_out(carry_out),
		.zero_out(zero_out), .acc_out(acc_out), .aux_out(aux_out), .halted(halted));
	cps_mem_model mem (.clk(clk), .fetch_req(fetch_req), .fetch_data(fetch_data),
		.ram_req(ram_req), .ram_rdata(ram_rdata));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task put(input logic [13:0] a, input logic [7:0] b[$]);
		foreach (b[k])
			mem.prog[a + 14'(k)] = b[k];
	endtask
	task clear_mem;
		foreach (mem.prog[k])
			mem.prog[k] = 8'h00;
		foreach (mem.ram[k])
			mem.ram[k] = 8'h00;
	endtask
	task start;
		@(posedge clk);
		resetn <= 1'h0;
		irq_req <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
	endtask
	task wait_halt;
		for (i = 0; i < 3000 && halted !== 1'h1; i++)
			@(negedge clk);
		chk8("halted", 8'h01, {7'h00, halted});
	endtask
	// Immediate, indexed and direct operands with push and pop around zero
	task test_data_stack;
		clear_mem();
		put(14'h0000, '{8'h19, 8'h30, 8'h1C, 8'h03, 8'h2D, 8'h1B, 8'h10, 8'h31, 8'h40, 8'h2B, 8'h30, 8'h2E, 8'h00});
		mem.ram[8'h13] = 8'h5A;
		start();
		wait_halt();
		chk8("push at top", 8'h30, mem.ram[8'hFF]);
		chk8("indexed load stored direct", 8'h5A, mem.ram[8'h40]);
		chk8("push after swap", 8'h03, mem.ram[8'h2F]);
		chk8("acc after swap", 8'h00, acc_out);
		chk8("aux", 8'h03, aux_out);
		$display("test data stack done");
	endtask
	// Loaded call stack, call and return, page advance, jump, wrap inside a page
	task test_call_page;
		clear_mem();
		put(14'h0000, '{8'h19, 8'h08, 8'h60, 8'h50, 8'h10, 8'h80, 8'hFF});
		put(14'h0010, '{8'h3F});
		put(14'h00FF, '{8'h1F});
		put(14'h0100, '{8'h82, 8'hFF});
		put(14'h0200, '{8'h5C, 8'h00});
		put(14'h02FF, '{8'h1C});
		@(posedge clk);
		carry_in <= 1'h1;
		start();
		wait_halt();
		chk8("saved flags and page", 8'h80, mem.ram[8'h08]);
		chk8("saved low address", 8'h05, mem.ram[8'h09]);
		chk8("operand after page wrap", 8'h5C, aux_out);
		chk8("acc", 8'h08, acc_out);
		chk8("carry kept", 8'h01, {7'h00, carry_out});
		@(posedge clk);
		carry_in <= 1'h0;
		$display("test call page done");
	endtask
	// Interrupt entry, nested return path through a preset frame
	task test_interrupt;
		clear_mem();
		put(14'h0000, '{8'h72, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h73, 8'h1C, 8'h77, 8'h00});
		mem.ram[8'hFF] = 8'h07;
		start();
		for (i = 0; i < 200 && irq_enabled !== 1'h1; i++)
			@(negedge clk);
		@(posedge clk);
		irq_req <= 1'h1;
		for (i = 0; i < 200 && irq_ack !== 1'h1; i++)
			@(negedge clk);
		chk8("ack", 8'h01, {7'h00, irq_ack});
		@(posedge clk);
		irq_req <= 1'h0;
		wait_halt();
		chk8("saved page byte", 8'h00, mem.ram[8'h00]);
		chk8("saved next address", 8'h01, {7'h00, mem.ram[8'h01] inside {[8'h01:8'h06]}});
		chk8("enable after return", 8'h01, {7'h00, irq_enabled});
		chk8("return target from preset frame", 8'h77, aux_out);
		chk8("zero after return", 8'h00, {7'h00, zero_out});
		$display("test interrupt done");
	endtask
	// Main sequence
	initial
	begin
		clk = 1'h0;
		resetn = 1'h0;
		irq_req = 1'h0;
		carry_in = 1'h0;
		zero_in = 1'h0;
		errors = 0;
		tests_run = 0;
		test_data_stack();
		test_call_page();
		test_interrupt();
		finish_test();
	end
	// Watchdog against a hang
	initial
	begin
		#(25 * 20000);
		errors++;
		$display("mismatch watchdog expected done seen timeout");
		finish_test();
	end
endmodule // cps_core_bench
bind cps_core cps_core_asserts u_chk (.clk(clk), .resetn(resetn), .fetch_req(fetch_req), .ram_req(ram_req),
	.irq_req(irq_req), .irq_ack(irq_ack), .irq_enabled(irq_enabled), .acc_out(acc_out));
`default_nettype wire
